// [hs_mon_pkg.sv]
package hs_mon_pkg;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_HZ       = 25_000_000;
   localparam int unsigned WARN_DELAY_S = 10;
   localparam int unsigned WARN_CYC     = WARN_DELAY_S * CLK_HZ;
   localparam int unsigned CNT_W        = 28;

   // -----------------------------------------------------------------
   // Temperatures in tenths of a degree
   // -----------------------------------------------------------------
   localparam int unsigned TEMP_W    = 12;
   localparam int unsigned LIM_W     = 10;
   localparam logic [9:0]  LIM_MIN   = 10'h15E;
   localparam logic [9:0]  LIM_MAX   = 10'h28A;
   localparam logic [9:0]  LIM_RST   = 10'h1F4;
   localparam logic [13:0] BAND_5K   = 14'h0032;
   localparam logic [6:0]  RATIO_MAX = 7'h64;
   localparam logic [6:0]  RATIO_MIN = 7'h32;
   localparam int unsigned ZONES     = 32;
   localparam int unsigned ZIDX_W    = 5;

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_LIMIT  = 8'h00;
   localparam logic [7:0] OFS_CH1    = 8'h04;
   localparam logic [7:0] OFS_CH2    = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_MON    = 8'h10;

   // -----------------------------------------------------------------
   // Channel configuration fields
   // -----------------------------------------------------------------
   localparam int unsigned CFG_W      = 14;
   localparam int unsigned CFG_L1_LSB = 0;
   localparam int unsigned CFG_L2_LSB = 2;
   localparam int unsigned CFG_SENS   = 4;
   localparam int unsigned CFG_RST    = 5;
   localparam int unsigned CFG_HS     = 6;
   localparam int unsigned CFG_SYS    = 7;
   localparam int unsigned CFG_CUR    = 8;
   localparam int unsigned CFG_LEAK   = 9;
   localparam int unsigned CFG_C1_LSB = 10;
   localparam int unsigned CFG_C2_LSB = 12;
   localparam logic [13:0] CH1_RST    = 14'h3C11;
   localparam logic [13:0] CH2_RST    = 14'h3D04;

   // -----------------------------------------------------------------
   // Status field positions
   // -----------------------------------------------------------------
   localparam int unsigned ST_RATIO_LSB = 12;
   localparam int unsigned ST_WARN      = 20;
   localparam int unsigned ST_ALARM     = 21;
   localparam int unsigned ST_CONT      = 22;
   localparam int unsigned ST_HS        = 23;
   localparam int unsigned MON_COL_LSB  = 2;
   localparam int unsigned MON_LEAK     = 6;
   localparam int unsigned MON_ZONE_LSB = 7;

   typedef enum logic [1:0] {
      LNK_OFF    = 2'b00,
      LNK_SINGLE = 2'b01,
      LNK_ALL    = 2'b10
   } link_mode_t;

   typedef enum logic [1:0] {
      COL_NONE   = 2'b00,
      COL_GREEN  = 2'b01,
      COL_ORANGE = 2'b10,
      COL_RED    = 2'b11
   } colour_t;

endpackage : hs_mon_pkg

// [heatsink_derate_monitor_signal.sv]
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/10ps
module heatsink_derate_monitor_signal
#(
   parameter int unsigned WARN_CYCLES = hs_mon_pkg::WARN_CYC
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [11:0] hs_temp,
   input  wire logic [31:0] zone_on,
   input  wire logic [31:0] zone_lim1,
   input  wire logic [31:0] zone_lim2,
   input  wire logic        sensor_err,
   input  wire logic        restart_evt,
   input  wire logic        system_err,
   input  wire logic        current_viol,
   input  wire logic        leak_det,
   input  wire logic [4:0]  leak_zone_in,
   output logic [6:0]       ratio_cap,
   output logic             warn_yellow,
   output logic             alarm_red,
   output logic             contactor_on,
   output logic             heatsink_evt,
   output logic             relay1,
   output logic             relay2,
   output logic [1:0]       colour1,
   output logic [1:0]       colour2,
   output logic             leak_flag,
   output logic [4:0]       leak_zone
);

   // ----------------------------------------------------------------
   // Input bundle and state
   // ----------------------------------------------------------------
   localparam int unsigned IN_W = 12 + 3 * 32 + 5 + 5;

   typedef struct packed {
      logic [11:0] temp;
      logic [31:0] on;
      logic [31:0] l1;
      logic [31:0] l2;
      logic        sens;
      logic        rst;
      logic        sys;
      logic        cur;
      logic        leak;
      logic [4:0]  lzone;
   } in_t;

   typedef struct packed {
      logic [IN_W-1:0]  s1;
      logic [IN_W-1:0]  s2;
      logic [IN_W-1:0]  s3;
      in_t              inp;
      logic [9:0]       limit;
      logic [1:0][13:0] cfg;
      logic [27:0]      warn_cnt;
      logic [27:0]      alarm_cnt;
      logic             warn;
      logic             alarm;
      logic [6:0]       ratio;
      logic             contactor;
      logic             hs_evt;
      logic             leak_lat;
      logic [4:0]       leak_zone;
      logic [1:0]       relay;
      logic [1:0][1:0]  colour;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
   } state_t;

   state_t r;
   state_t nxt;

   // ----------------------------------------------------------------
   // Heat sink comparisons
   // ----------------------------------------------------------------
   logic [13:0] t_ext;
   logic [13:0] l_ext;
   logic [13:0] t_up;
   logic        near;
   logic        at_lim;
   logic        over_lim;
   logic        trip;
   logic [13:0] excess;
   logic [27:0] warn_last;

   assign t_ext     = {2'b00, r.inp.temp};
   assign l_ext     = {4'h0, r.limit};
   assign t_up      = t_ext + hs_mon_pkg::BAND_5K;
   assign near      = t_up >= l_ext;
   assign at_lim    = t_ext >= l_ext;
   assign over_lim  = t_ext > l_ext;
   assign trip      = t_ext >= l_ext + hs_mon_pkg::BAND_5K;
   assign excess    = t_up - l_ext;
   assign warn_last = 28'(WARN_CYCLES - 1);

   // ----------------------------------------------------------------
   // Monitoring channels
   // ----------------------------------------------------------------
   logic [1:0]      ch_act;
   logic [1:0][1:0] ch_col;
   logic            any1;
   logic            all1;
   logic            any2;
   logic            all2;

   assign any1 = |(r.inp.l1 & r.inp.on);
   assign all1 = (r.inp.on != 32'h0) &&
                 ((r.inp.l1 & r.inp.on) == r.inp.on);
   assign any2 = |(r.inp.l2 & r.inp.on);
   assign all2 = (r.inp.on != 32'h0) &&
                 ((r.inp.l2 & r.inp.on) == r.inp.on);

   genvar c;
   generate
      for (c = 0; c < 2; c++)
      begin : g_ch
         logic [13:0] cf;
         logic        l1_hit;
         logic        l2_hit;
         logic [1:0]  c1;
         logic [1:0]  c2;
         logic        red;
         logic        orange;
         logic        green;

         assign cf = r.cfg[c];
         assign c1 = cf[hs_mon_pkg::CFG_C1_LSB +: 2];
         assign c2 = cf[hs_mon_pkg::CFG_C2_LSB +: 2];

         always_comb
         begin
            case (cf[hs_mon_pkg::CFG_L1_LSB +: 2])
               hs_mon_pkg::LNK_SINGLE: l1_hit = any1;
               hs_mon_pkg::LNK_ALL:    l1_hit = all1;
               default:                l1_hit = 1'b0;
            endcase
            case (cf[hs_mon_pkg::CFG_L2_LSB +: 2])
               hs_mon_pkg::LNK_SINGLE: l2_hit = any2;
               hs_mon_pkg::LNK_ALL:    l2_hit = all2;
               default:                l2_hit = 1'b0;
            endcase
         end

         assign red = (cf[hs_mon_pkg::CFG_SENS] & r.inp.sens)
                    | (cf[hs_mon_pkg::CFG_SYS] & r.inp.sys)
                    | (cf[hs_mon_pkg::CFG_CUR] & r.inp.cur)
                    | (cf[hs_mon_pkg::CFG_LEAK] & r.leak_lat)
                    | (cf[hs_mon_pkg::CFG_HS] & r.hs_evt)
                    | (l1_hit & (c1 == hs_mon_pkg::COL_RED))
                    | (l2_hit & (c2 == hs_mon_pkg::COL_RED));
         assign orange = (cf[hs_mon_pkg::CFG_RST] & r.inp.rst)
                       | (l1_hit & (c1 == hs_mon_pkg::COL_ORANGE))
                       | (l2_hit & (c2 == hs_mon_pkg::COL_ORANGE));
         assign green = (l1_hit & (c1 == hs_mon_pkg::COL_GREEN))
                      | (l2_hit & (c2 == hs_mon_pkg::COL_GREEN));

         assign ch_act[c] = red | orange | green | l1_hit | l2_hit;
         assign ch_col[c] = red    ? hs_mon_pkg::COL_RED :
                            orange ? hs_mon_pkg::COL_ORANGE :
                            green  ? hs_mon_pkg::COL_GREEN :
                                     hs_mon_pkg::COL_NONE;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic        setup;
   logic        access;
   logic        mapped;
   logic [31:0] rd;

   assign setup  = psel & ~penable;
   assign access = psel & penable & r.pready;

   always_comb
   begin
      nxt = r;

      // Input synchroniser; a change counts when stages two and three agree
      nxt.s1 = {hs_temp, zone_on, zone_lim1, zone_lim2, sensor_err,
                restart_evt, system_err, current_viol, leak_det,
                leak_zone_in};
      nxt.s2 = r.s1;
      nxt.s3 = r.s2;
      if (r.s2 == r.s3)
      begin
         nxt.inp = in_t'(r.s3);
      end

      // Derating of all zone output ratios
      if (at_lim)
      begin
         nxt.ratio = hs_mon_pkg::RATIO_MIN;
      end
      else if (near)
      begin
         nxt.ratio = hs_mon_pkg::RATIO_MAX - excess[6:0];
      end
      else
      begin
         nxt.ratio = hs_mon_pkg::RATIO_MAX;
      end

      // Delayed warning and alarm indications
      if (!near)
      begin
         nxt.warn_cnt = 28'h0;
         nxt.warn     = 1'b0;
      end
      else if (r.warn_cnt == warn_last)
      begin
         nxt.warn = 1'b1;
      end
      else
      begin
         nxt.warn_cnt = r.warn_cnt + 28'h1;
      end
      if (!at_lim)
      begin
         nxt.alarm_cnt = 28'h0;
         nxt.alarm     = 1'b0;
      end
      else if (r.alarm_cnt == warn_last)
      begin
         nxt.alarm = 1'b1;
      end
      else
      begin
         nxt.alarm_cnt = r.alarm_cnt + 28'h1;
      end

      nxt.contactor = ~trip;
      nxt.hs_evt    = over_lim;

      // Leakage holds until reset
      if (r.inp.leak && !r.leak_lat)
      begin
         nxt.leak_lat  = 1'b1;
         nxt.leak_zone = r.inp.lzone;
      end

      nxt.relay  = ch_act;
      nxt.colour = ch_col;

      // Register access
      mapped = 1'b1;
      rd     = 32'h0;
      case (paddr)
         hs_mon_pkg::OFS_LIMIT:  rd[9:0] = r.limit;
         hs_mon_pkg::OFS_CH1:    rd[13:0] = r.cfg[0];
         hs_mon_pkg::OFS_CH2:    rd[13:0] = r.cfg[1];
         hs_mon_pkg::OFS_STATUS:
         begin
            rd[11:0] = r.inp.temp;
            rd[hs_mon_pkg::ST_RATIO_LSB +: 7] = r.ratio;
            rd[hs_mon_pkg::ST_WARN]  = r.warn;
            rd[hs_mon_pkg::ST_ALARM] = r.alarm;
            rd[hs_mon_pkg::ST_CONT]  = r.contactor;
            rd[hs_mon_pkg::ST_HS]    = r.hs_evt;
         end
         hs_mon_pkg::OFS_MON:
         begin
            rd[1:0] = r.relay;
            rd[hs_mon_pkg::MON_COL_LSB +: 4] = r.colour;
            rd[hs_mon_pkg::MON_LEAK] = r.leak_lat;
            rd[hs_mon_pkg::MON_ZONE_LSB +: 5] = r.leak_zone;
         end
         default: mapped = 1'b0;
      endcase

      nxt.pready  = setup;
      if (setup)
      begin
         nxt.prdata  = pwrite ? 32'h0 : rd;
         nxt.pslverr = ~mapped;
      end
      else
      begin
         nxt.prdata  = 32'h0;
         nxt.pslverr = 1'b0;
      end

      if (access && pwrite && mapped)
      begin
         case (paddr)
            hs_mon_pkg::OFS_LIMIT:
            begin
               if (pwdata[9:0] >= hs_mon_pkg::LIM_MIN &&
                   pwdata[9:0] <= hs_mon_pkg::LIM_MAX &&
                   pwdata[31:10] == 22'h0)
               begin
                  nxt.limit = pwdata[9:0];
               end
            end
            hs_mon_pkg::OFS_CH1: nxt.cfg[0] = pwdata[13:0];
            hs_mon_pkg::OFS_CH2: nxt.cfg[1] = pwdata[13:0];
            default: nxt.limit = r.limit;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r           <= '0;
         r.limit     <= hs_mon_pkg::LIM_RST;
         r.cfg[0]    <= hs_mon_pkg::CH1_RST;
         r.cfg[1]    <= hs_mon_pkg::CH2_RST;
         r.ratio     <= hs_mon_pkg::RATIO_MAX;
      end
      else if (ce)
      begin
         r <= nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata       = r.prdata;
   assign pready       = r.pready;
   assign pslverr      = r.pslverr;
   assign ratio_cap    = r.ratio;
   assign warn_yellow  = r.warn;
   assign alarm_red    = r.alarm;
   assign contactor_on = r.contactor;
   assign heatsink_evt = r.hs_evt;
   assign relay1       = r.relay[0];
   assign relay2       = r.relay[1];
   assign colour1      = r.colour[0];
   assign colour2      = r.colour[1];
   assign leak_flag    = r.leak_lat;
   assign leak_zone    = r.leak_zone;

endmodule : heatsink_derate_monitor_signal

// [hs_mon_monitor.sv]
`timescale 1ns/10ps
module hs_mon_monitor
#(
   parameter int unsigned WARN_CYCLES = 20
)
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       ce,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic [6:0] ratio_cap,
   input wire logic       warn_yellow,
   input wire logic       alarm_red,
   input wire logic       contactor_on,
   input wire logic       heatsink_evt,
   input wire logic       relay1,
   input wire logic       relay2,
   input wire logic [1:0] colour1,
   input wire logic [1:0] colour2,
   input wire logic       leak_flag,
   input wire logic [4:0] leak_zone
);
   // ----------------------------------------------------------------
   // Helpers and properties
   // ----------------------------------------------------------------
   logic [1:0] live_r;
   logic [7:0] c50_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         live_r <= 2'h0;
         c50_r  <= 8'h00;
      end
      else
      begin
         if (live_r != 2'h3)
            live_r <= live_r + 2'h1;
         if (ratio_cap != hs_mon_pkg::RATIO_MIN)
            c50_r <= 8'h00;
         else if (c50_r != 8'hFF)
            c50_r <= c50_r + 8'h01;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence

   property p_apb_ready;
      s_setup ##1 s_access |-> pready;
   endproperty
   property p_err_ready;
      pslverr |-> pready;
   endproperty
   property p_ratio_range;
      ratio_cap >= hs_mon_pkg::RATIO_MIN && ratio_cap <= hs_mon_pkg::RATIO_MAX;
   endproperty
   property p_alarm_ratio;
      alarm_red |-> ratio_cap == hs_mon_pkg::RATIO_MIN && warn_yellow;
   endproperty
   property p_hs_ratio;
      heatsink_evt |-> ratio_cap == hs_mon_pkg::RATIO_MIN;
   endproperty
   property p_cont_off;
      live_r == 2'h3 && !contactor_on |-> heatsink_evt;
   endproperty
   property p_alarm_delay;
      $rose(alarm_red) |-> c50_r >= WARN_CYCLES - 2;
   endproperty
   property p_leak_hold;
      leak_flag |=> leak_flag && $stable(leak_zone);
   endproperty
   property p_col1;
      !relay1 |-> colour1 == hs_mon_pkg::COL_NONE;
   endproperty
   property p_col2;
      !relay2 |-> colour2 == hs_mon_pkg::COL_NONE;
   endproperty
   property p_ce_hold;
      !ce |=> $stable({ratio_cap, warn_yellow, alarm_red, contactor_on,
                       relay1, relay2, leak_flag, pready});
   endproperty

   a_apb_ready: assert property (p_apb_ready)
      else $error("pready missing in access cycle");
   a_err_ready: assert property (p_err_ready)
      else $error("pslverr without pready");
   a_ratio_range: assert property (p_ratio_range)
      else $error("ratio cap out of range");
   a_alarm_ratio: assert property (p_alarm_ratio)
      else $error("alarm without full derate and warning");
   a_hs_ratio: assert property (p_hs_ratio)
      else $error("over-limit event without full derate");
   a_cont_off: assert property (p_cont_off)
      else $error("contactor open below limit");
   a_alarm_delay: assert property (p_alarm_delay)
      else $error("alarm raised too early");
   a_leak_hold: assert property (p_leak_hold)
      else $error("leak latch lost");
   a_col1: assert property (p_col1)
      else $error("colour one without signal");
   a_col2: assert property (p_col2)
      else $error("colour two without signal");
   a_ce_hold: assert property (p_ce_hold)
      else $error("state moved while clock enable low");
endmodule : hs_mon_monitor

bind heatsink_derate_monitor_signal hs_mon_monitor
   #(.WARN_CYCLES(WARN_CYCLES)) u_hs_mon_monitor
(
   .pclk, .presetn, .ce, .psel, .penable, .pready, .pslverr, .ratio_cap,
   .warn_yellow, .alarm_red, .contactor_on, .heatsink_evt, .relay1,
   .relay2, .colour1, .colour2, .leak_flag, .leak_zone
);

// [hs_sensor_model.sv]
`timescale 1ns/10ps
module hs_sensor_model
#(
   parameter int unsigned PERIOD = 4
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] heat_req,
   output logic      [11:0] hs_temp
);
   // ----------------------------------------------------------------
   // Sensor: a fresh reading every PERIOD cycles
   // ----------------------------------------------------------------
   int unsigned cnt_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_r   <= 0;
         hs_temp <= 12'h000;
      end
      else if (cnt_r + 1 >= PERIOD)
      begin
         cnt_r   <= 0;
         hs_temp <= heat_req;
      end
      else
         cnt_r <= cnt_r + 1;
   end
endmodule : hs_sensor_model

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
   // ----------------------------------------------------------------
   // Stimulus and checks
   // ----------------------------------------------------------------
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        ce = 1'b1;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [11:0] heat_req = 12'h12C;
   logic [31:0] zone_on = 32'h0;
   logic [31:0] zone_lim1 = 32'h0;
   logic [31:0] zone_lim2 = 32'h0;
   logic [4:0]  evt = 5'h00;
   logic [4:0]  leak_zone_in = 5'h00;
   logic [31:0] prdata;
   logic        pready, pslverr, warn_yellow, alarm_red, contactor_on;
   logic        heatsink_evt, relay1, relay2, leak_flag;
   logic [11:0] hs_temp;
   logic [6:0]  ratio_cap;
   logic [1:0]  colour1, colour2;
   logic [4:0]  leak_zone;
   int          fails = 0;
   int          checked = 0;

   heatsink_derate_monitor_signal #(.WARN_CYCLES(20))
      u_heatsink_derate_monitor_signal
   (
      .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .hs_temp, .zone_on, .zone_lim1,
      .zone_lim2, .sensor_err(evt[0]), .restart_evt(evt[1]),
      .system_err(evt[2]), .current_viol(evt[3]), .leak_det(evt[4]),
      .leak_zone_in, .ratio_cap, .warn_yellow, .alarm_red, .contactor_on,
      .heatsink_evt, .relay1, .relay2, .colour1, .colour2, .leak_flag,
      .leak_zone
   );

   hs_sensor_model u_hs_sensor_model (.pclk, .presetn, .heat_req, .hs_temp);

   always #20 pclk = ~pclk;

   task automatic print_verdict;
      if (fails == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      chk("pready", 32'h1, 32'(pready));
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
      chk("pslverr", 32'h0, 32'(e));
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk("prdata", x, q);
   endtask : rd

   task automatic settle;
      repeat (14) @(posedge pclk);
   endtask : settle

   task automatic t_reset;
      logic [31:0] q;
      logic        e;
      rd(8'h00, 32'h1F4);
      rd(8'h04, 32'h3C11);
      rd(8'h08, 32'h3D04);
      apb(1'b0, 8'h14, 32'h0, q, e);
      chk("unmapped", 32'h1, 32'(e));
      evt <= 5'h01;
      settle();
      chk("rst_sens", 32'h1, 32'({relay2, relay1}));
      evt <= 5'h08;
      settle();
      chk("rst_cur", 32'h2, 32'({relay2, relay1}));
      evt <= 5'h00;
   endtask : t_reset

   task automatic t_limit;
      logic [31:0] wv [4] = '{32'h15E, 32'h15D, 32'h28B, 32'h28A};
      logic [31:0] rv [4] = '{32'h15E, 32'h15E, 32'h15E, 32'h28A};
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h00, wv[i]);
         rd(8'h00, rv[i]);
      end
      wr(8'h00, 32'h15E);
      heat_req <= 12'h14A;
      settle();
      chk("ratio_lo", 32'h46, 32'(ratio_cap));
      wr(8'h00, 32'h1F4);
   endtask : t_limit

   task automatic t_derate;
      logic [11:0] tv [6] = '{12'h12C, 12'h1D6, 12'h1F4, 12'h1F5, 12'h225,
                               12'h226};
      logic [8:0]  xv [6] = '{9'h164, 9'h150, 9'h132, 9'h1B2, 9'h1B2,
                               9'h0B2};
      for (int i = 0; i < 6; i++)
      begin
         heat_req <= tv[i];
         settle();
         chk("derate", 32'(xv[i]),
             32'({contactor_on, heatsink_evt, ratio_cap}));
      end
      heat_req <= 12'h12C;
      settle();
      rd(8'h0C, 32'h46412C);
   endtask : t_derate

   task automatic t_hold;
      ce       <= 1'b0;
      heat_req <= 12'h1D6;
      settle();
      chk("ce_hold", 32'h64, 32'(ratio_cap));
      ce <= 1'b1;
      settle();
      chk("ce_run", 32'h50, 32'(ratio_cap));
      heat_req <= 12'h12C;
      settle();
   endtask : t_hold

   task automatic t_warn;
      heat_req <= 12'h1D6;
      settle();
      chk("warn_early", 32'h0, 32'(warn_yellow));
      repeat (24) @(posedge pclk);
      chk("warn", 32'h1, 32'({alarm_red, warn_yellow}));
      heat_req <= 12'h1F4;
      settle();
      chk("alarm_early", 32'h0, 32'(alarm_red));
      repeat (24) @(posedge pclk);
      chk("alarm", 32'h3, 32'({alarm_red, warn_yellow}));
      heat_req <= 12'h12C;
      settle();
      chk("clear", 32'h0, 32'({alarm_red, warn_yellow}));
   endtask : t_warn

   task automatic t_sources;
      logic [3:0] bn [4] = '{4'h4, 4'h5, 4'h7, 4'h8};
      logic [1:0] cl [4] = '{2'h3, 2'h2, 2'h3, 2'h3};
      wr(8'h08, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h04, 32'h1 << bn[i]);
         evt <= 5'h01 << i;
         settle();
         chk("src", 32'({2'b01, cl[i]}), 32'({relay2, relay1, colour1}));
         evt <= 5'h00;
         settle();
         chk("src_off", 32'h0, 32'(relay1));
      end
      wr(8'h04, 32'h0);
      evt <= 5'h0F;
      settle();
      chk("disabled", 32'h0, 32'(relay1));
      wr(8'h04, 32'h30);
      evt <= 5'h03;
      settle();
      chk("prio", 32'h3, 32'(colour1));
      evt <= 5'h02;
      settle();
      chk("orange", 32'h2, 32'(colour1));
      evt <= 5'h00;
      wr(8'h04, 32'h40);
      heat_req <= 12'h208;
      settle();
      chk("hs_src", 32'h7, 32'({relay1, colour1}));
      heat_req <= 12'h12C;
      settle();
   endtask : t_sources

   task automatic zcase(input logic [13:0] c1, input logic [13:0] c2,
                        input logic [31:0] on, input logic [31:0] l1,
                        input logic [31:0] l2, input logic [5:0] x);
      wr(8'h04, 32'(c1));
      wr(8'h08, 32'(c2));
      zone_on   <= on;
      zone_lim1 <= l1;
      zone_lim2 <= l2;
      settle();
      chk("zone", 32'(x), 32'({colour2, colour1, relay2, relay1}));
   endtask : zcase

   task automatic t_zones;
      zcase(14'h0401, 14'h2008, 32'h3, 32'h1, 32'h1, 6'h05);
      zcase(14'h0401, 14'h2008, 32'h3, 32'h0, 32'h3, 6'h22);
      zcase(14'h0004, 14'h0002, 32'h1, 32'h1, 32'h1, 6'h03);
      zcase(14'h0000, 14'h0003, 32'h3, 32'h3, 32'h3, 6'h00);
   endtask : t_zones

   task automatic t_leak;
      wr(8'h04, 32'h200);
      leak_zone_in <= 5'h07;
      evt <= 5'h10;
      settle();
      chk("leak", 32'h13F,
          32'({leak_flag, leak_zone, relay1, colour1}));
      evt <= 5'h00;
      leak_zone_in <= 5'h02;
      settle();
      chk("leak_hold", 32'h27, 32'({leak_flag, leak_zone}));
      rd(8'h10, 32'h3CD);
   endtask : t_leak

   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_limit();
      t_derate();
      t_hold();
      t_warn();
      t_sources();
      t_zones();
      t_leak();
      print_verdict();
   end

   initial
   begin
      repeat (6000) @(posedge pclk);
      fails++;
      print_verdict();
   end
endmodule : tb_top
